// file: include/rdcp_pkg.sv
// Package for the rear digital control port: map, function codes, carriers
package rdcp_pkg;
	localparam int CH_N = 10;                        // Channels 1..10
	localparam int DW   = 32;                        // Register data width
	localparam int VW   = 6;                         // Port value width
	localparam int FW   = 4;                         // Function code width
	// Register byte addresses
	localparam logic [7:0] IN_ADDR   = 8'h00;        // Input value, read only
	localparam logic [7:0] OUT_ADDR  = 8'h04;        // Output value
	localparam logic [7:0] STAT_ADDR = 8'h08;        // Refusal flag
	localparam logic [7:0] CH_BASE   = 8'h40;        // Channel 1 config
	localparam logic [7:0] CH_LAST   = 8'h64;        // Channel 10 config
	localparam int POL_BIT = 8;                      // Polarity bit in config word
	localparam int ERR_BIT = 0;                      // Refusal bit in status word
	// Channel groups
	localparam int A_LO = 1;
	localparam int A_HI = 3;
	localparam int SHUT_CH = 4;
	localparam int B_LO = 5;
	localparam int B_HI = 7;
	localparam int PROT_CH = 8;
	localparam int C_LO = 9;
	// Port value bit positions
	localparam int IN_A_LSB = 0;                     // Channels 1..3 user inputs
	localparam int IN_B_LSB = 3;                     // Channels 5..7 user outputs echo
	localparam int OUT_USER_LSB = 3;                 // Drives channels 5..7
	// Polarity
	localparam logic POL_POS = 1'b0;                 // High is true
	localparam logic POL_NEG = 1'b1;                 // Low is true
	localparam logic POL_CH4 = POL_POS;              // Fixed shutdown polarity
	localparam logic [CH_N:1] POL_RST   = 10'h000;   // All positive after reset
	localparam logic [CH_N:1] POL_FIXED = 10'h008;   // Channel 4 locked
	// Function codes, common
	localparam logic [FW-1:0] FN_UNUSED     = 4'h0;
	localparam logic [FW-1:0] FN_SHUTDOWN   = 4'hd;  // Reads back on channel 4
	localparam logic [FW-1:0] FN_PROTECTION = 4'he;  // Reads back on channel 8
	// Group A, channels 1..3, inputs
	localparam logic [FW-1:0] FN_A_OUT_ON = 4'h1;    // output_on_request
	localparam logic [FW-1:0] FN_A_BLOCK  = 4'hb;    // output_block_input
	localparam logic [FW-1:0] FN_A_USER   = 4'hc;    // user_input_signal
	// Group B, channels 5..7, status outputs
	localparam logic [FW-1:0] FN_B_SEQ  = 4'ha;      // sequence_state_indication
	localparam logic [FW-1:0] FN_B_USER = 4'hb;      // User programmed output
	// Group C, channels 9..10
	localparam logic [FW-1:0] FN_C_CLK_RX  = 4'h1;   // sync_clock_receive
	localparam logic [FW-1:0] FN_C_TRIG_RX = 4'h2;   // sequence_trigger_receive
	localparam logic [FW-1:0] FN_C_CLK_TX  = 4'h3;   // reference_clock_send
	localparam logic [FW-1:0] FN_C_TRIG_TX = 4'h4;   // sequence_trigger_send
	// Requests to the instrument, bit 0 is code 1
	typedef struct packed {
		logic output_block_input;
		logic preset_two_recall;
		logic preset_one_recall;
		logic voltage_range_select;
		logic wiring_select_three_phase;
		logic wiring_select_split_phase;
		logic wiring_select_single_phase;
		logic external_protection_input;
		logic protection_clear_request;
		logic sequence_run_request;
		logic output_on_request;
	} rdcp_req_t;
	// Status from the instrument, bit 0 is code 1
	typedef struct packed {
		logic sequence_state_indication;
		logic powered_up_indication;
		logic high_range_indication;
		logic three_phase_wiring_indication;
		logic split_phase_wiring_indication;
		logic single_phase_wiring_indication;
		logic busy_indication;
		logic overload_indication;
		logic peak_current_limit_indication;
		logic output_on_indication;
	} rdcp_stat_t;
endpackage

// file: hw/rdcp_pol_store.sv
// Polarity selections with load from and save to non-volatile storage
`timescale 1ns/1ps
module rdcp_pol_store (
	input  wire logic                       ref_clk_in,
	input  wire logic                       rst_in,
	input  wire logic [rdcp_pkg::CH_N:1]    pol_we_in,
	input  wire logic                       pol_val_in,
	input  wire logic                       nv_load_in,
	input  wire logic [rdcp_pkg::CH_N:1]    nv_pol_in,
	output logic      [rdcp_pkg::CH_N:1]    pol_out,
	output logic                            nv_save_out
);
	logic [rdcp_pkg::CH_N:1] pol_q;   // Current selections
	logic [rdcp_pkg::CH_N:1] pol_d;   // Next selections
	logic                    save_q;  // Save request pulse

	// Next value: stored copy wins, then software, fixed bits never move
	always_comb begin
		pol_d = pol_q;
		if (nv_load_in) begin
			pol_d = nv_pol_in;
		end else begin
			pol_d = (pol_q & ~pol_we_in) | ({rdcp_pkg::CH_N{pol_val_in}} & pol_we_in);
		end
		pol_d = (pol_d & ~rdcp_pkg::POL_FIXED) | (rdcp_pkg::POL_RST & rdcp_pkg::POL_FIXED);
	end

	// Selection register
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pol_q <= rdcp_pkg::POL_RST;
		end else begin
			pol_q <= pol_d;
		end
	end

	// Ask storage to keep a copy whenever software changes a selection
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			save_q <= 1'b0;
		end else begin
			save_q <= !nv_load_in && (pol_d != pol_q);
		end
	end

	assign pol_out     = pol_q;
	assign nv_save_out = save_q;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	property p_nv_save;
		!nv_load_in && (pol_d != pol_q) |=> nv_save_out && (pol_out == $past(pol_d));
	endproperty
	a_nv_save: assert property (p_nv_save) else $error("polarity change not saved");

	property p_pol_fixed;
		pol_out[rdcp_pkg::SHUT_CH] == rdcp_pkg::POL_CH4;
	endproperty
	a_pol_fixed: assert property (p_pol_fixed) else $error("channel 4 polarity moved");
endmodule // rdcp_pol_store

// file: hw/rdcp_port.sv
// Rear digital control port: channel mapping, polarity, port values, registers
// Behaviour
// - Input value reads as six-bit number
// - Output value stored, driven, read back
// - Channels 1-3,5-7,9,10 take selectable functions
// - Channels 1-3 offer only input functions
// - Channels 5-7 offer only output functions
// - Channels 9-10 offer clock/trigger functions only
// - Mappable channels start unused after reset
// - Channels 4, 8 fixed; remap refused
// - Channel 4 polarity cannot change
// - Polarity selections kept in non-volatile storage
// - Function and polarity readable per channel
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module rdcp_port (
	input  wire logic                       ref_clk_in,
	input  wire logic                       rst_in,
	input  wire logic [7:0]                 addr_in,
	input  wire logic [rdcp_pkg::DW-1:0]    wr_data_in,
	input  wire logic                       wr_in,
	input  wire logic                       rd_in,
	output logic      [rdcp_pkg::DW-1:0]    rd_data_out,
	input  wire logic [rdcp_pkg::CH_N:1]    pin_level_in,
	output logic      [rdcp_pkg::CH_N:1]    pin_drive_out,
	output logic      [rdcp_pkg::CH_N:1]    pin_oe_n_out,
	input  rdcp_pkg::rdcp_stat_t            status_in,
	input  wire logic                       protection_in,
	input  wire logic                       reference_clock_send_in,
	input  wire logic                       sequence_trigger_send_in,
	output rdcp_pkg::rdcp_req_t             req_out,
	output logic                            shutdown_out,
	output logic                            sync_clock_receive_out,
	output logic                            sequence_trigger_receive_out,
	input  wire logic                       nv_load_in,
	input  wire logic [rdcp_pkg::CH_N:1]    nv_pol_in,
	output logic      [rdcp_pkg::CH_N:1]    nv_pol_out,
	output logic                            nv_save_out
);
	logic [rdcp_pkg::CH_N:1][rdcp_pkg::FW-1:0] chan_fn;   // Function per channel
	logic [rdcp_pkg::CH_N:1]    pol;        // Polarity per channel
	logic [rdcp_pkg::CH_N:1]    lin;        // Logical input levels
	logic [rdcp_pkg::CH_N:1]    hit;        // Config write per channel
	logic [rdcp_pkg::CH_N:1]    refuse;     // Refused config write
	logic [rdcp_pkg::CH_N:1]    pol_we;     // Polarity write enables
	logic [7:0]                 ch_off;     // Offset into config block
	logic [rdcp_pkg::FW-1:0]    ch_idx;     // Addressed channel
	logic                       ch_sel;     // Address in config block
	logic [rdcp_pkg::VW-1:0]    out_data_q; // Output value
	logic [rdcp_pkg::VW-1:0]    in_d;       // Input value, next
	logic [rdcp_pkg::VW-1:0]    in_data_q;  // Input value, sampled
	logic                       refused_q;  // Sticky refusal flag
	logic [rdcp_pkg::FN_A_BLOCK:1] req_v;   // Request vector by code
	logic [rdcp_pkg::FN_B_SEQ:0]   stat_v;  // Status vector by code
	logic [rdcp_pkg::CH_N:1]    drv_en;     // Channel drives its pin
	logic [rdcp_pkg::CH_N:1]    drv_lvl;    // Pin level to drive
	logic                       sync_d;     // Sync clock from pins
	logic                       trig_d;     // Trigger from pins
	logic [rdcp_pkg::DW-1:0]    rd_d;       // Read data, next
	logic [rdcp_pkg::DW-1:0]    rd_q;       // Read data
	logic [rdcp_pkg::CH_N:1]    pin_q;      // Pin levels
	logic [rdcp_pkg::CH_N:1]    oe_n_q;     // Pin enables, low drives
	rdcp_pkg::rdcp_req_t        req_q;      // Registered requests
	logic                       shut_q;     // Registered shutdown
	logic                       sync_q;     // Registered sync clock
	logic                       trig_q;     // Registered trigger

	// Legal code for the channel's group
	function automatic logic fn_legal(input int ch, input logic [rdcp_pkg::FW-1:0] code);
		if (ch <= rdcp_pkg::A_HI) begin
			return code <= rdcp_pkg::FN_A_USER;
		end else if (ch <= rdcp_pkg::B_HI) begin
			return code <= rdcp_pkg::FN_B_USER;
		end
		return code <= rdcp_pkg::FN_C_TRIG_TX;
	endfunction

	// Config block decode
	assign ch_off = addr_in - rdcp_pkg::CH_BASE;
	assign ch_sel = (addr_in >= rdcp_pkg::CH_BASE) && (addr_in <= rdcp_pkg::CH_LAST) && (addr_in[1:0] == 2'h0);
	assign ch_idx = ch_off[5:2] + 4'h1;

	// Per channel function register or fixed function
	for (genvar g = 1; g <= rdcp_pkg::CH_N; g++) begin : g_ch
		assign hit[g] = wr_in && ch_sel && (ch_idx == 4'(g));
		if (g == rdcp_pkg::SHUT_CH || g == rdcp_pkg::PROT_CH) begin : g_fix
			localparam logic [rdcp_pkg::FW-1:0] FIX_FN =
				(g == rdcp_pkg::SHUT_CH) ? rdcp_pkg::FN_SHUTDOWN : rdcp_pkg::FN_PROTECTION;
			assign chan_fn[g] = FIX_FN;
			// Any other function, or a polarity change on channel 4, is refused
			assign refuse[g] = hit[g] && ((wr_data_in[rdcp_pkg::FW-1:0] != FIX_FN) ||
				((g == rdcp_pkg::SHUT_CH) && (wr_data_in[rdcp_pkg::POL_BIT] != rdcp_pkg::POL_CH4)));
			assign pol_we[g] = hit[g] && !refuse[g];
		end else begin : g_map
			logic [rdcp_pkg::FW-1:0] fn_q; // Chosen function
			logic                    ok;   // Code legal here
			assign ok = fn_legal(g, wr_data_in[rdcp_pkg::FW-1:0]);
			// Function register, unused after reset
			always_ff @(posedge ref_clk_in) begin
				if (rst_in) begin
					fn_q <= rdcp_pkg::FN_UNUSED;
				end else if (hit[g] && ok) begin
					fn_q <= wr_data_in[rdcp_pkg::FW-1:0];
				end
			end
			assign chan_fn[g] = fn_q;
			assign refuse[g]  = hit[g] && !ok;
			assign pol_we[g]  = hit[g] && ok;
		end
	end

	// Polarity selections and their non-volatile copy
	rdcp_pol_store u_pol (
		.ref_clk_in  (ref_clk_in),
		.rst_in      (rst_in),
		.pol_we_in   (pol_we),
		.pol_val_in  (wr_data_in[rdcp_pkg::POL_BIT]),
		.nv_load_in  (nv_load_in),
		.nv_pol_in   (nv_pol_in),
		.pol_out     (pol),
		.nv_save_out (nv_save_out)
	);
	assign nv_pol_out = pol;

	// Pin level to logical value
	assign lin    = pin_level_in ^ pol;
	assign stat_v = {status_in, 1'b0};

	// Route channels to functions and port value bits
	always_comb begin
		req_v   = '0;
		in_d    = '0;
		drv_en  = '0;
		drv_lvl = '0;
		sync_d  = 1'b0;
		trig_d  = 1'b0;
		for (int c = 1; c <= rdcp_pkg::CH_N; c++) begin
			if (c <= rdcp_pkg::A_HI) begin
				// Input group
				if (chan_fn[c] == rdcp_pkg::FN_A_USER) begin
					in_d[rdcp_pkg::IN_A_LSB + c - rdcp_pkg::A_LO] = lin[c];
				end else if (chan_fn[c] != rdcp_pkg::FN_UNUSED) begin
					req_v[chan_fn[c]] = req_v[chan_fn[c]] | lin[c];
				end
			end else if (c >= rdcp_pkg::B_LO && c <= rdcp_pkg::B_HI) begin
				// Status group, undriven when unused
				drv_en[c] = chan_fn[c] != rdcp_pkg::FN_UNUSED;
				if (chan_fn[c] == rdcp_pkg::FN_B_USER) begin
					in_d[rdcp_pkg::IN_B_LSB + c - rdcp_pkg::B_LO] = lin[c];
					drv_lvl[c] = out_data_q[rdcp_pkg::OUT_USER_LSB + c - rdcp_pkg::B_LO] ^ pol[c];
				end else begin
					drv_lvl[c] = stat_v[chan_fn[c]] ^ pol[c];
				end
			end else if (c == rdcp_pkg::PROT_CH) begin
				// Protection always driven
				drv_en[c]  = 1'b1;
				drv_lvl[c] = protection_in ^ pol[c];
			end else if (c >= rdcp_pkg::C_LO) begin
				// Clock and trigger group
				case (chan_fn[c])
					rdcp_pkg::FN_C_CLK_RX: sync_d = sync_d | lin[c];
					rdcp_pkg::FN_C_TRIG_RX: trig_d = trig_d | lin[c];
					rdcp_pkg::FN_C_CLK_TX: begin
						drv_en[c]  = 1'b1;
						drv_lvl[c] = reference_clock_send_in ^ pol[c];
					end
					rdcp_pkg::FN_C_TRIG_TX: begin
						drv_en[c]  = 1'b1;
						drv_lvl[c] = sequence_trigger_send_in ^ pol[c];
					end
					default: ;
				endcase
			end
		end
	end

	// Pins and instrument-side signals, all registered
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pin_q  <= '0;
			oe_n_q <= '1;
			req_q  <= '0;
			shut_q <= 1'b0;
			sync_q <= 1'b0;
			trig_q <= 1'b0;
		end else begin
			pin_q  <= drv_lvl;
			oe_n_q <= ~drv_en;
			req_q  <= rdcp_pkg::rdcp_req_t'(req_v);
			shut_q <= lin[rdcp_pkg::SHUT_CH];
			sync_q <= sync_d;
			trig_q <= trig_d;
		end
	end

	// Input value sampled every cycle
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			in_data_q <= '0;
		end else begin
			in_data_q <= in_d;
		end
	end

	// Output value register
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			out_data_q <= '0;
		end else if (wr_in && addr_in == rdcp_pkg::OUT_ADDR) begin
			out_data_q <= wr_data_in[rdcp_pkg::VW-1:0];
		end
	end

	// Refusal flag, a new refusal beats a clear
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			refused_q <= 1'b0;
		end else if (|refuse) begin
			refused_q <= 1'b1;
		end else if (wr_in && addr_in == rdcp_pkg::STAT_ADDR && wr_data_in[rdcp_pkg::ERR_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// Read mux, unmapped reads return zero
	always_comb begin
		rd_d = '0;
		if (addr_in == rdcp_pkg::IN_ADDR) begin
			rd_d[rdcp_pkg::VW-1:0] = in_data_q;
		end else if (addr_in == rdcp_pkg::OUT_ADDR) begin
			rd_d[rdcp_pkg::VW-1:0] = out_data_q;
		end else if (addr_in == rdcp_pkg::STAT_ADDR) begin
			rd_d[rdcp_pkg::ERR_BIT] = refused_q;
		end else if (ch_sel) begin
			rd_d[rdcp_pkg::FW-1:0]  = chan_fn[ch_idx];
			rd_d[rdcp_pkg::POL_BIT] = pol[ch_idx];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_in ? rd_d : '0;
		end
	end

	assign rd_data_out                  = rd_q;
	assign pin_drive_out                = pin_q;
	assign pin_oe_n_out                 = oe_n_q;
	assign req_out                      = req_q;
	assign shutdown_out                 = shut_q;
	assign sync_clock_receive_out       = sync_q;
	assign sequence_trigger_receive_out = trig_q;

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_out_write;
		wr_in && addr_in == rdcp_pkg::OUT_ADDR;
	endsequence
	sequence s_out_readback;
		!wr_in && rd_in && addr_in == rdcp_pkg::OUT_ADDR;
	endsequence
	property p_in_read;
		rd_in && addr_in == rdcp_pkg::IN_ADDR |=>
			rd_data_out == {26'h0, $past(in_data_q)};
	endproperty
	a_in_read: assert property (p_in_read) else $error("input value read wrong");
	// Write, one quiet cycle, then read back the output value
	property p_out_store;
		s_out_write ##1 !wr_in ##1 s_out_readback |=> rd_data_out[5:0] == $past(wr_data_in[5:0], 3);
	endproperty
	a_out_store: assert property (p_out_store) else $error("output value readback wrong");
	property p_user_drive;
		chan_fn[5] == rdcp_pkg::FN_B_USER |=>
			!pin_oe_n_out[5] && pin_drive_out[5] == $past(out_data_q[3] ^ pol[5]);
	endproperty
	a_user_drive: assert property (p_user_drive) else $error("user output not driven");
	property p_req_map;
		chan_fn[1] == rdcp_pkg::FN_A_OUT_ON && (pin_level_in[1] ^ pol[1]) |=> req_out.output_on_request;
	endproperty
	a_req_map: assert property (p_req_map) else $error("request not routed");
	// Negative user input on channel 2 reads as the inverse of its wire
	property p_neg_pol;
		pol[2] && chan_fn[2] == rdcp_pkg::FN_A_USER |=> in_data_q[1] != $past(pin_level_in[2]);
	endproperty
	a_neg_pol: assert property (p_neg_pol) else $error("negative polarity read wrong");
	property p_legal;
		chan_fn[1] <= rdcp_pkg::FN_A_USER && chan_fn[6] <= rdcp_pkg::FN_B_USER &&
			chan_fn[10] <= rdcp_pkg::FN_C_TRIG_TX;
	endproperty
	a_legal: assert property (p_legal) else $error("illegal function held");
	property p_reset_unused;
		$fell(rst_in) |-> chan_fn[1] == rdcp_pkg::FN_UNUSED && chan_fn[7] == rdcp_pkg::FN_UNUSED &&
			chan_fn[9] == rdcp_pkg::FN_UNUSED && pin_oe_n_out[7];
	endproperty
	a_reset_unused: assert property (p_reset_unused) else $error("channel not unused after reset");
	property p_fixed_refuse;
		wr_in && addr_in == 8'h4c && wr_data_in[3:0] != rdcp_pkg::FN_SHUTDOWN |=>
			refused_q && chan_fn[4] == rdcp_pkg::FN_SHUTDOWN;
	endproperty
	a_fixed_refuse: assert property (p_fixed_refuse) else $error("channel 4 remap accepted");
	property p_cfg_read;
		rd_in && addr_in == rdcp_pkg::CH_BASE |=>
			rd_data_out[3:0] == $past(chan_fn[1]) && rd_data_out[8] == $past(pol[1]);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
endmodule // rdcp_port

// file: bench/rdcp_equip.sv
// Model of the equipment wired to the rear control connector
`timescale 1ns/1ps
module rdcp_equip (
	input  wire logic [rdcp_pkg::CH_N:1] drive_in,   // Level driven by the port
	input  wire logic [rdcp_pkg::CH_N:1] oe_n_in,    // Port enable, low drives
	input  wire logic [rdcp_pkg::CH_N:1] ext_en_in,  // Equipment drives channel
	input  wire logic [rdcp_pkg::CH_N:1] ext_lvl_in, // Equipment level
	output logic      [rdcp_pkg::CH_N:1] level_out   // Resolved wire level
);
	// Wire resolution, idle lines pulled up
	always_comb begin
		for (int c = 1; c <= rdcp_pkg::CH_N; c++) begin
			if (!oe_n_in[c] && ext_en_in[c]) begin
				level_out[c] = 1'bx;            // Contention shows as unknown
			end else if (!oe_n_in[c]) begin
				level_out[c] = drive_in[c];     // Port drives
			end else if (ext_en_in[c]) begin
				level_out[c] = ext_lvl_in[c];   // Equipment drives
			end else begin
				level_out[c] = 1'b1;            // Pull-up on an idle line
			end
		end
	end
endmodule // rdcp_equip

// file: bench/test_rdcp_port.sv
// Self-checking bench for the rear digital control port
`timescale 1ns/1ps
module test_rdcp_port;
	logic                    ref_clk_in;   // 200 MHz clock
	logic                    rst_in;       // Synchronous reset
	logic [7:0]              addr_in;      // Register address
	logic [31:0]             wr_data_in;   // Write data
	logic                    wr_in;        // Write strobe
	logic                    rd_in;        // Read strobe
	logic [31:0]             rd_data_out;  // Read data
	logic [10:1]             pin_level;    // Resolved wires
	logic [10:1]             pin_drive;    // Port drive levels
	logic [10:1]             pin_oe_n;     // Port enables
	logic [10:1]             ext_en;       // Equipment enables
	logic [10:1]             ext_lvl;      // Equipment levels
	rdcp_pkg::rdcp_stat_t    status_in;    // Instrument status
	logic                    prot_in;      // Protection status
	logic                    clk_tx;       // Clock to send
	logic                    trig_tx;      // Trigger to send
	rdcp_pkg::rdcp_req_t     req_out;      // Logical requests
	logic                    shut_out;     // Shutdown request
	logic                    sync_rx;      // Received clock
	logic                    trig_rx;      // Received trigger
	logic                    nv_load;      // Storage load pulse
	logic [10:1]             nv_pol_in;    // Stored polarities
	logic [10:1]             nv_pol_out;   // Current polarities
	logic                    nv_save;      // Save request
	int                      miscompares;  // Mismatch count
	int                      n_tests;      // Comparison count
	int                      cnt;          // Pulse counter
	int                      tch[6] = '{5, 9, 4, 4, 8, 1};
	logic [31:0]             tdat[6] = '{32'h00c, 32'h005, 32'h000, 32'h10d, 32'h000, 32'h00d};
	logic [31:0]             texp[6] = '{32'h00b, 32'h000, 32'h00d, 32'h00d, 32'h00e, 32'h10c};

	rdcp_port u_rdcp_port (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in),
		.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.pin_level_in(pin_level), .pin_drive_out(pin_drive), .pin_oe_n_out(pin_oe_n),
		.status_in(status_in), .protection_in(prot_in), .reference_clock_send_in(clk_tx),
		.sequence_trigger_send_in(trig_tx), .req_out(req_out), .shutdown_out(shut_out),
		.sync_clock_receive_out(sync_rx), .sequence_trigger_receive_out(trig_rx),
		.nv_load_in(nv_load), .nv_pol_in(nv_pol_in), .nv_pol_out(nv_pol_out), .nv_save_out(nv_save));

	rdcp_equip u_rdcp_equip (.drive_in(pin_drive), .oe_n_in(pin_oe_n), .ext_en_in(ext_en),
		.ext_lvl_in(ext_lvl), .level_out(pin_level));

	// Clock, 5 ns period
	always #2.5 ref_clk_in = ~ref_clk_in;

	// Channel config address
	function automatic logic [7:0] cfg(input int c);
		return rdcp_pkg::CH_BASE + 8'(4 * (c - 1));
	endfunction

	// Compare and report
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			miscompares++;
		end
	endtask

	// One-cycle write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge ref_clk_in);
		wr_in <= 1'b0;
	endtask

	// One-cycle read, data checked in the following cycle
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		@(posedge ref_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge ref_clk_in);
		rd_in <= 1'b0;
		#1;
		chk(nm, exp, rd_data_out);
	endtask

	// Let pins and requests follow
	task automatic settle();
		repeat (3) @(posedge ref_clk_in);
		#1;
	endtask

	// Verdict and end of run
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		miscompares++;
		test_done();
	end

	// Main sequence
	initial begin
		ref_clk_in = 1'b0; rst_in = 1'b1; addr_in = 8'h00; wr_data_in = 32'h0; wr_in = 1'b0;
		rd_in = 1'b0; ext_en = 10'h000; ext_lvl = 10'h000; status_in = '0; prot_in = 1'b0;
		clk_tx = 1'b0; trig_tx = 1'b0; nv_load = 1'b0; nv_pol_in = 10'h000;
		miscompares = 0; n_tests = 0;
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		// Defaults after reset
		for (int c = 1; c <= 10; c++) begin
			rd_chk(cfg(c), (c == 4) ? 32'h00d : (c == 8) ? 32'h00e : 32'h000, "cfg");
		end
		chk("oe_n", 32'h37f, 32'(pin_oe_n));
		// Every request function on channel 1, wire high
		@(posedge ref_clk_in);
		ext_en <= 10'h007;
		ext_lvl <= 10'h001;
		for (int k = 1; k <= 11; k++) begin
			wr(cfg(1), 32'(k));
			settle();
			chk("req", 32'(11'h001 << (k - 1)), 32'(req_out));
		end
		// User inputs with mixed polarity
		wr(cfg(1), 32'h00c);
		wr(cfg(2), 32'h10c);
		wr(cfg(3), 32'h00c);
		settle();
		chk("req_user", 32'h0, 32'(req_out));
		rd_chk(rdcp_pkg::IN_ADDR, 32'h03, "in");
		wr(cfg(1), 32'h10c);
		cnt = 0;
		for (int i = 0; i < 4; i++) begin
			#1;
			cnt += int'(nv_save);
			@(posedge ref_clk_in);
		end
		chk("save", 32'h1, 32'(cnt));
		rd_chk(rdcp_pkg::IN_ADDR, 32'h02, "in_neg");
		// User outputs on channels 5 to 7
		wr(cfg(5), 32'h00b);
		wr(cfg(6), 32'h00b);
		wr(cfg(7), 32'h10b);
		wr(rdcp_pkg::OUT_ADDR, 32'h28);
		rd_chk(rdcp_pkg::OUT_ADDR, 32'h28, "out_now");
		settle();
		chk("drive", 32'h010, 32'(pin_drive & 10'h070));
		chk("oe_out", 32'h0, 32'(pin_oe_n & 10'h070));
		rd_chk(rdcp_pkg::OUT_ADDR, 32'h28, "out");
		rd_chk(rdcp_pkg::IN_ADDR, 32'h2a, "in_out");
		// Every status function on channel 6
		for (int k = 1; k <= 10; k++) begin
			@(posedge ref_clk_in);
			status_in <= rdcp_pkg::rdcp_stat_t'(10'h001 << (k - 1));
			wr(cfg(6), 32'(k));
			settle();
			chk("stat_on", 32'h1, 32'(pin_drive[6]));
			@(posedge ref_clk_in);
			status_in <= rdcp_pkg::rdcp_stat_t'(~(10'h001 << (k - 1)));
			settle();
			chk("stat_off", 32'h0, 32'(pin_drive[6]));
		end
		// Refused config writes
		for (int i = 0; i < 6; i++) begin
			wr(rdcp_pkg::STAT_ADDR, 32'h1);
			wr(cfg(tch[i]), tdat[i]);
			rd_chk(cfg(tch[i]), texp[i], "refused_cfg");
			rd_chk(rdcp_pkg::STAT_ADDR, 32'h1, "refused_flag");
		end
		wr(rdcp_pkg::STAT_ADDR, 32'h1);
		rd_chk(rdcp_pkg::STAT_ADDR, 32'h0, "flag_clear");
		rd_chk(8'h0c, 32'h0, "unmapped");
		// Clock and trigger channels
		@(posedge ref_clk_in);
		clk_tx <= 1'b1;
		ext_en <= 10'h20f;
		ext_lvl <= 10'h209;
		prot_in <= 1'b1;
		wr(cfg(9), 32'h003);
		wr(cfg(10), 32'h001);
		settle();
		chk("clk_tx", 32'h1, 32'({pin_drive[9], pin_oe_n[9]} == 2'b10));
		chk("sync_rx", 32'h1, 32'(sync_rx));
		chk("shutdown", 32'h1, 32'(shut_out));
		chk("prot", 32'h1, 32'({pin_drive[8], pin_oe_n[8]} == 2'b10));
		@(posedge ref_clk_in);
		clk_tx <= 1'b0;
		trig_tx <= 1'b1;
		wr(cfg(9), 32'h004);
		wr(cfg(10), 32'h002);
		settle();
		chk("trig_tx", 32'h1, 32'(pin_drive[9]));
		chk("trig_rx", 32'h1, 32'(trig_rx));
		// Load from storage, channel 4 stays positive
		@(posedge ref_clk_in);
		nv_pol_in <= 10'h3ff;
		nv_load <= 1'b1;
		@(posedge ref_clk_in);
		nv_load <= 1'b0;
		settle();
		chk("nv_pol", 32'h3f7, 32'(nv_pol_out));
		rd_chk(cfg(3), 32'h10c, "cfg3");
		rd_chk(cfg(4), 32'h00d, "cfg4");
		// Second reset mid-run
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd_chk(cfg(5), 32'h000, "cfg_rst");
		test_done();
	end
endmodule // test_rdcp_port
